// *** core/flrf_formatter.sv ***
// Purpose: Builds and serves the byte image of the fault log
// Assumes: All inputs come from logic on core_clk
// Notes: Peak compare is on raw codes; upstream keeps them ordered
`timescale 1ns/1ps
`default_nettype none
`include "flrf_map.svh"

module flrf_formatter
	import flrf_pkg::*;
#(
	parameter logic [31:0] SIGNATURE = 32'h464C_3031 // Arbitrary value
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sampleValid,
	input wire logic faultStrobe,
	input wire logic faultChannel,
	input wire flrf_pkg::flrf_byte_t faultCause,
	input wire logic explicitLogStore,
	input wire logic peakClear,
	input wire logic logClear,
	input wire logic [47:0] sharedTimeCounter,
	input wire flrf_pkg::flrf_word_t voutCh0,
	input wire flrf_pkg::flrf_word_t voutCh1,
	input wire flrf_pkg::flrf_word_t ioutCh0,
	input wire flrf_pkg::flrf_word_t ioutCh1,
	input wire flrf_pkg::flrf_word_t vinValue,
	input wire flrf_pkg::flrf_word_t tempExt0,
	input wire flrf_pkg::flrf_word_t tempExt1,
	input wire flrf_pkg::flrf_word_t tempInternal,
	input wire flrf_pkg::flrf_byte_t voutStatus0,
	input wire flrf_pkg::flrf_byte_t voutStatus1,
	input wire flrf_pkg::flrf_word_t statusWord0,
	input wire flrf_pkg::flrf_word_t statusWord1,
	input wire flrf_pkg::flrf_byte_t vendorStatus0,
	input wire flrf_pkg::flrf_byte_t vendorStatus1,
	input wire logic readStrobe,
	input wire flrf_pkg::flrf_byte_t readAddr,
	output flrf_pkg::flrf_byte_t readData,
	output logic readValid,
	output flrf_pkg::flrf_byte_t byteCount,
	output logic logPresent
);
	import flrf_pkg::*;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	localparam int RECW = `FLRF_REC_LEN * 8;
	localparam int HDRW = `FLRF_HDR_LEN * 8;

	function automatic flrf_word_t larger(flrf_word_t a, flrf_word_t b);
		larger = (b > a) ? b : a;
	endfunction

	function automatic logic [47:0] lowFirst(logic [47:0] v);
		for (int i = 0; i < 6; i++) begin
			lowFirst[47 - 8 * i -: 8] = v[8 * i +: 8];
		end
	endfunction

	flrf_state_t state, next_state;
	logic [RECW-1:0] rec [`FLRF_REC_NUM];
	logic [RECW-1:0] next_rec [`FLRF_REC_NUM];
	flrf_byte_t srcCode, next_srcCode;
	logic [47:0] timeHold, next_timeHold;
	flrf_word_t voutPk0, voutPk1, ioutPk0, ioutPk1, vinPk;
	flrf_word_t next_voutPk0, next_voutPk1, next_ioutPk0;
	flrf_word_t next_ioutPk1, next_vinPk;
	flrf_word_t hdrTemp0, hdrTemp1, hdrTempInt;
	flrf_word_t next_hdrTemp0, next_hdrTemp1, next_hdrTempInt;
	flrf_byte_t next_readData, next_byteCount;
	logic next_readValid, next_logPresent;
	logic trigger;
	logic [RECW-1:0] newRec;
	logic [HDRW-1:0] hdrImage;

	// Snapshot of one ADC cycle, byte 0 in the top lane
	assign newRec = {voutCh0, voutCh1, ioutCh0, ioutCh1, vinValue,
		16'h0000,
		voutStatus0, voutStatus1, statusWord0, statusWord1,
		vendorStatus0, vendorStatus1};

	assign hdrImage = {SIGNATURE,
		srcCode,
		lowFirst(timeHold),
		voutPk0, voutPk1,
		ioutPk0, ioutPk1,
		vinPk,
		hdrTemp0, hdrTemp1, hdrTempInt};

	assign trigger = (state == LOG_RECORDING) &&
		(faultStrobe || explicitLogStore);

	// Log capture and record history
	always_comb begin
		next_state = state;
		next_srcCode = srcCode;
		next_timeHold = timeHold;
		next_hdrTemp0 = hdrTemp0;
		next_hdrTemp1 = hdrTemp1;
		next_hdrTempInt = hdrTempInt;
		next_rec = rec;
		case (state)
			LOG_RECORDING: begin
				// History freezes once held so the host sees a steady image
				if (sampleValid || trigger) begin
					for (int i = `FLRF_REC_NUM - 1; i > 0; i--) begin
						next_rec[i] = rec[i - 1];
					end
					next_rec[0] = newRec;
				end
				if (trigger) begin
					next_state = LOG_HELD;
					next_timeHold = sharedTimeCounter;
					next_hdrTemp0 = tempExt0;
					next_hdrTemp1 = tempExt1;
					next_hdrTempInt = tempInternal;
					// A real fault outranks a store landing in the same cycle
					if (faultStrobe) begin
						next_srcCode = faultChannel ?
							faultCause + `FLRF_SRC_CH1 : faultCause;
					end else begin
						next_srcCode = `FLRF_SRC_STORE;
					end
				end
			end
			LOG_HELD: begin
				if (logClear) begin
					next_state = LOG_RECORDING;
				end
			end
			default: begin
				next_state = LOG_RECORDING;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= LOG_RECORDING;
			srcCode <= 8'h00;
			timeHold <= 48'h0000_0000_0000;
			hdrTemp0 <= 16'h0000;
			hdrTemp1 <= 16'h0000;
			hdrTempInt <= 16'h0000;
			for (int i = 0; i < `FLRF_REC_NUM; i++) begin
				rec[i] <= '0;
			end
		end else begin
			state <= next_state;
			srcCode <= next_srcCode;
			timeHold <= next_timeHold;
			hdrTemp0 <= next_hdrTemp0;
			hdrTemp1 <= next_hdrTemp1;
			hdrTempInt <= next_hdrTempInt;
			rec <= next_rec;
		end
	end

	// Peaks: a sample in the clear cycle survives the clear
	always_comb begin
		next_voutPk0 = peakClear ? `FLRF_PEAK_RST : voutPk0;
		next_voutPk1 = peakClear ? `FLRF_PEAK_RST : voutPk1;
		next_ioutPk0 = peakClear ? `FLRF_PEAK_RST : ioutPk0;
		next_ioutPk1 = peakClear ? `FLRF_PEAK_RST : ioutPk1;
		next_vinPk = peakClear ? `FLRF_PEAK_RST : vinPk;
		if (sampleValid) begin
			next_voutPk0 = larger(next_voutPk0, voutCh0);
			next_voutPk1 = larger(next_voutPk1, voutCh1);
			next_ioutPk0 = larger(next_ioutPk0, ioutCh0);
			next_ioutPk1 = larger(next_ioutPk1, ioutCh1);
			next_vinPk = larger(next_vinPk, vinValue);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			voutPk0 <= `FLRF_PEAK_RST;
			voutPk1 <= `FLRF_PEAK_RST;
			ioutPk0 <= `FLRF_PEAK_RST;
			ioutPk1 <= `FLRF_PEAK_RST;
			vinPk <= `FLRF_PEAK_RST;
		end else begin
			voutPk0 <= next_voutPk0;
			voutPk1 <= next_voutPk1;
			ioutPk0 <= next_ioutPk0;
			ioutPk1 <= next_ioutPk1;
			vinPk <= next_vinPk;
		end
	end

	// Byte server; peaks in the header are live, as the host expects
	always_comb begin
		int ofs;
		int idx;
		ofs = 0;
		idx = 0;
		next_readData = readData;
		next_readValid = readStrobe;
		next_logPresent = (next_state == LOG_HELD);
		next_byteCount = next_logPresent ? `FLRF_LOG_LEN : 8'h00;
		if (readStrobe) begin
			next_readData = 8'h00;
			if (readAddr < 8'(`FLRF_HDR_LEN)) begin
				next_readData = hdrImage[HDRW - 1 - 8 * int'(readAddr) -: 8];
			end else if (readAddr < `FLRF_LOG_LEN) begin
				ofs = int'(readAddr) - `FLRF_REC_BASE;
				idx = ofs / `FLRF_REC_LEN;
				ofs = ofs % `FLRF_REC_LEN;
				next_readData = rec[idx][RECW - 1 - 8 * ofs -: 8];
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			readData <= 8'h00;
			readValid <= 1'b0;
			logPresent <= 1'b0;
			byteCount <= 8'h00;
		end else begin
			readData <= next_readData;
			readValid <= next_readValid;
			logPresent <= next_logPresent;
			byteCount <= next_byteCount;
		end
	end

	a_count_present: assert property (
		byteCount == (logPresent ? `FLRF_LOG_LEN : 8'h00))
		else $error("byte count disagrees with log presence");
	a_store_code: assert property (
		trigger && !faultStrobe |=> srcCode == `FLRF_SRC_STORE)
		else $error("store log lacks store code");
	a_chan1_code: assert property (
		trigger && faultStrobe && faultChannel
		|=> srcCode == $past(faultCause) + `FLRF_SRC_CH1)
		else $error("channel 1 source code wrong");
	a_sig_byte: assert property (
		readStrobe && readAddr == 8'h01 |=> readData == SIGNATURE[23:16])
		else $error("signature byte wrong");
	// A capture may land in the read cycle, so compare the old value
	a_time_low: assert property (
		readStrobe && readAddr == 8'(`FLRF_TS_OFS)
		|=> readData == $past(timeHold[7:0]))
		else $error("timestamp not low byte first");
	a_unused_zero: assert property (
		readStrobe && readAddr == 8'(`FLRF_REC_BASE + `FLRF_UNUSED_OFS + 1)
		|=> readData == 8'h00)
		else $error("unused record byte not zero");
	a_held_frozen: assert property (
		state == LOG_HELD |=> $stable(rec[0]) && $stable(rec[5]))
		else $error("history moved while held");
	a_fault_first: assert property (
		trigger |=> rec[0] == $past(newRec) && rec[1] == $past(rec[0]))
		else $error("fault record not newest");
	a_peak_clear: assert property (
		peakClear && !sampleValid |=> vinPk == `FLRF_PEAK_RST)
		else $error("peak not cleared");
	a_vout_peak: assert property (
		readStrobe && readAddr == 8'h0B |=> readData == $past(voutPk0[15:8]))
		else $error("output voltage peak byte wrong");
endmodule
`default_nettype wire

// *** inc/flrf_map.svh ***
// Purpose: Offsets, sizes and reset values of the fault log image
// Assumes: Byte 0 is the first byte returned by the block read
// Notes: Record N sits at FLRF_REC_BASE + N * FLRF_REC_LEN
`ifndef FLRF_MAP_SVH
`define FLRF_MAP_SVH
`define FLRF_HDR_LEN 27
`define FLRF_REC_LEN 20
`define FLRF_REC_NUM 6
`define FLRF_REC_BASE 27
`define FLRF_LOG_LEN 8'h93
`define FLRF_SRC_STORE 8'hFF
`define FLRF_SRC_CH1 8'h10
`define FLRF_TS_OFS 5
`define FLRF_UNUSED_OFS 10
`define FLRF_PEAK_RST 16'h0000
`endif

// *** inc/flrf_pkg.sv ***
// Purpose: Types shared by the fault log formatter
// Assumes: Nothing beyond the map header
// Notes: Log states plus byte and word types; codes are left to the tool
package flrf_pkg;
	typedef enum logic {LOG_RECORDING, LOG_HELD} flrf_state_t;
	typedef logic [7:0] flrf_byte_t;
	typedef logic [15:0] flrf_word_t;
endpackage

// *** dv/flrf_host_reader.sv ***
// Purpose: Host side that fetches log image bytes one at a time
// Assumes: Answer comes one cycle after the strobe is taken
// Notes: Idle address shows the inverted last value, never a stale one
`timescale 1ns/1ps
`default_nettype none
module flrf_host_reader (
	input wire logic core_clk,
	input wire logic readValid,
	input wire logic [7:0] readData,
	output logic readStrobe,
	output logic [7:0] readAddr
);
	initial begin
		readStrobe = 1'b0;
		readAddr = 8'h00;
	end
	// Fetch one byte of the fixed-length block
	task automatic fetch(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge core_clk);
		#1 readStrobe = 1'b1;
		readAddr = a;
		@(posedge core_clk);
		#1 readStrobe = 1'b0;
		readAddr = ~a;
		v = readValid;
		d = readData;
	endtask
endmodule
`default_nettype wire

// *** dv/flrf_formatter_test.sv ***
// Purpose: Self-checking bench for the fault log formatter
// Assumes: Design signature parameter left at its default
// Notes: Time counter and temperatures change once, after the first capture
`timescale 1ns/1ps
`default_nettype none
module flrf_formatter_test;
	import flrf_pkg::*;
	logic core_clk = 0, resetn = 0, sampleValid = 0, faultStrobe = 0;
	logic faultChannel = 0, explicitLogStore = 0, peakClear = 0;
	logic logClear = 0, readStrobe, readValid, logPresent, v;
	logic [47:0] sharedTimeCounter = 48'h6655_4433_2211;
	flrf_word_t voutCh0, voutCh1, ioutCh0, ioutCh1, vinValue;
	flrf_word_t statusWord0, statusWord1, tempExt0 = 16'hA1A2;
	flrf_word_t tempExt1 = 16'hB1B2, tempInternal = 16'hC1C2;
	flrf_byte_t faultCause = 8'h00, voutStatus0, voutStatus1, d;
	flrf_byte_t vendorStatus0, vendorStatus1, readData, readAddr, byteCount;
	flrf_byte_t codes [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06,
		8'h07, 8'h0A};
	int error_cnt = 0, checks_done = 0;
	flrf_formatter u_dut (.core_clk, .resetn, .sampleValid, .faultStrobe,
		.faultChannel, .faultCause, .explicitLogStore, .peakClear, .logClear,
		.sharedTimeCounter, .voutCh0, .voutCh1, .ioutCh0, .ioutCh1,
		.vinValue, .tempExt0, .tempExt1, .tempInternal, .voutStatus0,
		.voutStatus1, .statusWord0, .statusWord1, .vendorStatus0,
		.vendorStatus1, .readStrobe, .readAddr, .readData, .readValid,
		.byteCount, .logPresent);
	flrf_host_reader u_host (.core_clk, .readValid, .readData, .readStrobe,
		.readAddr);
	always #12.5 core_clk = ~core_clk;
	function automatic flrf_byte_t f(input int s, input int i);
		return {s[2:0], i[4:0]};
	endfunction
	// Expected byte b of the image after the first capture
	function automatic flrf_byte_t img(input int b);
		logic [31:0] sig;
		sig = 32'h464C_3031;
		if (b < 4) return sig[31 - 8 * b -: 8];
		if (b == 4) return 8'h11;
		if (b < 11) return 8'(17 * (b - 4));
		if (b < 21) return f(7, b - 11);
		if (b < 27) return {4'(10 + (b - 21) / 2), 4'(2 - b % 2)};
		if (b > 146 || (b - 27) % 20 inside {10, 11}) return 8'h00;
		return f((b < 47) ? 1 : 8 - (b - 27) / 20, (b - 27) % 20);
	endfunction
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask
	task automatic put(input int s);
		voutCh0 = {f(s, 0), f(s, 1)};
		voutCh1 = {f(s, 2), f(s, 3)};
		ioutCh0 = {f(s, 4), f(s, 5)};
		ioutCh1 = {f(s, 6), f(s, 7)};
		vinValue = {f(s, 8), f(s, 9)};
		voutStatus0 = f(s, 12);
		voutStatus1 = f(s, 13);
		statusWord0 = {f(s, 14), f(s, 15)};
		statusWord1 = {f(s, 16), f(s, 17)};
		vendorStatus0 = f(s, 18);
		vendorStatus1 = f(s, 19);
	endtask
	task automatic chk(input flrf_byte_t seen, input flrf_byte_t exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input int a, input flrf_byte_t exp);
		u_host.fetch(8'(a), d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask
	task automatic ev(input logic fs, st, ch, input flrf_byte_t c);
		step;
		{faultStrobe, explicitLogStore, faultChannel, faultCause} = {fs, st, ch, c};
		step;
		{faultStrobe, explicitLogStore} = 2'b00;
	endtask
	task automatic clr;
		step;
		logClear = 1'b1;
		step;
		logClear = 1'b0;
		chk({7'h00, logPresent}, 8'h00);
		chk(byteCount, 8'h00);
	endtask
	task automatic t_image;
		for (int s = 2; s < 8; s++) begin
			step;
			put(s);
			sampleValid = 1'b1;
		end
		step;
		sampleValid = 1'b0;
		put(1);
		ev(1, 0, 1, 8'h01);
		chk({7'h00, logPresent}, 8'h01);
		chk(byteCount, 8'h93);
		// Header time stamp and temperatures must keep capture-time values, not follow the inputs
		sharedTimeCounter = ~sharedTimeCounter;
		{tempExt0, tempExt1, tempInternal} = 48'h0000_0000_0000;
		for (int b = 0; b < 150; b++) begin
			rd(b, img(b));
		end
		put(6);
		ev(1, 0, 0, 8'h02);
		rd(4, 8'h11);
		rd(27, f(1, 0));
		$display("test image done");
	endtask
	task automatic t_codes;
		for (int ch = 0; ch < 2; ch++)
			foreach (codes[k]) begin
				clr;
				ev(1, 0, ch[0], codes[k]);
				rd(4, codes[k] + 8'(16 * ch));
			end
		clr;
		ev(0, 1, 0, 8'h03);
		rd(4, 8'hFF);
		clr;
		ev(1, 1, 1, 8'h05);
		rd(4, 8'h15);
		$display("test codes done");
	endtask
	task automatic t_peak;
		clr;
		step;
		peakClear = 1'b1;
		step;
		peakClear = 1'b0;
		put(2);
		sampleValid = 1'b1;
		step;
		sampleValid = 1'b0;
		put(1);
		ev(1, 0, 0, 8'h07);
		for (int b = 11; b < 21; b++) rd(b, f(2, b - 11));
		$display("test peak done");
	endtask
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Full run is about 470 cycles; this leaves ample margin
	initial begin
		#200000;
		error_cnt++;
		report_and_stop;
	end
	initial begin
		put(0);
		repeat (20) @(posedge core_clk);
		#1 resetn = 1'b1;
		chk({7'h00, logPresent}, 8'h00);
		chk(byteCount, 8'h00);
		t_image;
		t_codes;
		t_peak;
		report_and_stop;
	end
endmodule
`default_nettype wire
